// ==== sbdp_top.v ====
// Purpose: Device-side data phase control of the system bus
// Assumes: Four beats presented one per core clock; link clock sampled
// Notes: Bus pins are split into in/out/oe; all outputs registered
`timescale 1ns/1ps
`include "sbdp_defines.vh"
// Functional notes
// R1: Driver holds busy low while owning bus
// R2: Bus free only after driver drops busy
// R3: Far agent asserts order_n_a for out-of-order
// R4: Inversion line marks group data inverted
// R5: Invert when over half bits toggle
// R6: Line n covers bits 16n+15 to 16n
// R7: Deep-sleep request moves Sleep to Deep Sleep
// R8: Request released returns to Sleep
// R9: Platform I/O controller drives deep-sleep request
// R10: Input buffer power control is ignored
// R11: Data valid low on every transfer
// R12: Idle clocks may be inserted, not captured
// R13: Sixty-four bit path in four groups
// R14: Four words per clock, strobe falling edges
// R15: Active low lines; compare with last wire
module sbdp_top #(
  parameter DW = `SBDP_DATA_W,
  parameter GW = `SBDP_GRP_W,
  parameter NG = `SBDP_NGRP
) (
  input wire core_clk_i,
  input wire nrst_i,
  input wire bus_clk_i,
  // Local send request: one word per beat
  input wire tx_start_i,
  input wire tx_beat_valid_i,
  input wire [DW-1:0] tx_data_i,
  input wire tx_last_i,
  output reg tx_ready_o,
  // Bus pins
  input wire data_bus_busy_n_i,
  output reg data_bus_busy_n_o,
  output reg data_bus_busy_n_oe_o,
  input wire data_valid_n_i,
  output reg data_valid_n_o,
  output reg data_valid_n_oe_o,
  input wire [DW-1:0] data_n_i,
  output reg [DW-1:0] data_n_o,
  output reg data_n_oe_o,
  input wire [NG-1:0] group_invert_n_i,
  output reg [NG-1:0] group_invert_n_o,
  output reg group_invert_n_oe_o,
  input wire [NG-1:0] data_strobe_pos_n_i,
  input wire [NG-1:0] data_strobe_neg_n_i,
  output reg [NG-1:0] data_strobe_pos_n_o,
  output reg [NG-1:0] data_strobe_neg_n_o,
  output reg data_strobe_oe_o,
  input wire order_n_a_i,
  input wire deep_sleep_req_n_i,
  input wire input_buffer_power_ctl_n_i,
  // Received data and status
  output reg [DW-1:0] rx_data_o,
  output reg rx_valid_o,
  output reg order_n_a_seen_o,
  output reg bus_free_o,
  output reg deep_sleep_o
);
  // Two-flop synchronisers for every bus input except the power control
  reg [2:0] bclk_s_reg;
  reg [1:0] busy_s_reg, data_valid_n_s_reg, order_n_a_s_reg, dslp_s_reg;
  reg [NG-1:0] sp_s1_reg, sp_s2_reg, sp_s3_reg;
  reg [NG-1:0] sn_s1_reg, sn_s2_reg, sn_s3_reg;
  reg [DW-1:0] din_s1_reg, din_s2_reg;
  reg [NG-1:0] inv_s1_reg, inv_s2_reg;
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bclk_s_reg <= 3'h0;
      busy_s_reg <= 2'h3;
      data_valid_n_s_reg <= 2'h3;
      order_n_a_s_reg <= 2'h3;
      dslp_s_reg <= 2'h3;
      sp_s1_reg <= {NG{1'b1}};
      sp_s2_reg <= {NG{1'b1}};
      sp_s3_reg <= {NG{1'b1}};
      sn_s1_reg <= {NG{1'b1}};
      sn_s2_reg <= {NG{1'b1}};
      sn_s3_reg <= {NG{1'b1}};
      din_s1_reg <= {DW{1'b1}};
      din_s2_reg <= {DW{1'b1}};
      inv_s1_reg <= {NG{1'b1}};
      inv_s2_reg <= {NG{1'b1}};
    end else begin
      bclk_s_reg <= {bclk_s_reg[1:0], bus_clk_i};
      busy_s_reg <= {busy_s_reg[0], data_bus_busy_n_i};
      data_valid_n_s_reg <= {data_valid_n_s_reg[0], data_valid_n_i};
      order_n_a_s_reg <= {order_n_a_s_reg[0], order_n_a_i};
      dslp_s_reg <= {dslp_s_reg[0], deep_sleep_req_n_i};
      sp_s1_reg <= data_strobe_pos_n_i;
      sp_s2_reg <= sp_s1_reg;
      sp_s3_reg <= sp_s2_reg;
      sn_s1_reg <= data_strobe_neg_n_i;
      sn_s2_reg <= sn_s1_reg;
      sn_s3_reg <= sn_s2_reg;
      din_s1_reg <= data_n_i;
      din_s2_reg <= din_s1_reg;
      inv_s1_reg <= group_invert_n_i;
      inv_s2_reg <= inv_s1_reg;
    end
  end
  // Rising edge of the sampled bus clock starts each common clock
  wire bclk_rise = bclk_s_reg[1] & ~bclk_s_reg[2];
  wire [NG-1:0] sp_fall = sp_s3_reg & ~sp_s2_reg;
  wire [NG-1:0] sn_fall = sn_s3_reg & ~sn_s2_reg;
  // Far agent owns the bus while its busy or valid is low
  wire far_busy = ~busy_s_reg[1];
  wire far_valid = ~data_valid_n_s_reg[1];

  // Inversion coding, one coder per group
  reg [DW-1:0] last_wire_reg;
  wire [DW-1:0] enc_wire;
  wire [NG-1:0] enc_inv;
  genvar g;
  generate
    for (g = 0; g < NG; g = g + 1) begin : grp
      sbdp_group_inv #(.W(GW)) u_inv (
        .data_i(tx_data_i[g*GW +: GW]), // [R6] [R13]
        .last_wire_i(last_wire_reg[g*GW +: GW]),
        .wire_o(enc_wire[g*GW +: GW]),
        .inv_o(enc_inv[g])
      );
    end
  endgenerate

  // Transmit phase machine
  reg [1:0] ph_reg, ph_next;
  reg [1:0] beat_reg;
  wire beat_go = tx_beat_valid_i & tx_ready_o;
  always @* begin
    ph_next = ph_reg;
    case (ph_reg)
      `SBDP_PH_IDLE: begin
        // Take the bus only once the far driver released it [R2]
        if (tx_start_i && !far_busy && !far_valid)
          ph_next = `SBDP_PH_XFER;
      end
      `SBDP_PH_XFER: begin
        if (beat_go && tx_last_i)
          ph_next = `SBDP_PH_REL;
        else if (!tx_beat_valid_i)
          ph_next = `SBDP_PH_GAP; // Idle clock inserted [R12]
      end
      `SBDP_PH_GAP: begin
        if (tx_beat_valid_i)
          ph_next = `SBDP_PH_XFER;
      end
      `SBDP_PH_REL: ph_next = `SBDP_PH_IDLE;
      default: ph_next = `SBDP_PH_IDLE;
    endcase
  end

  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph_reg <= `SBDP_PH_IDLE;
      beat_reg <= 2'h0;
      last_wire_reg <= {DW{1'b0}};
      tx_ready_o <= 1'b0;
      data_bus_busy_n_o <= 1'b1;
      data_bus_busy_n_oe_o <= 1'b0;
      data_valid_n_o <= 1'b1;
      data_valid_n_oe_o <= 1'b0;
      data_n_o <= {DW{1'b1}};
      data_n_oe_o <= 1'b0;
      group_invert_n_o <= {NG{1'b1}};
      group_invert_n_oe_o <= 1'b0;
      data_strobe_pos_n_o <= {NG{1'b1}};
      data_strobe_neg_n_o <= {NG{1'b1}};
      data_strobe_oe_o <= 1'b0;
    end else begin
      ph_reg <= ph_next;
      tx_ready_o <= (ph_next == `SBDP_PH_XFER) ||
                    (ph_next == `SBDP_PH_GAP);
      // Busy held low for the whole ownership [R1]
      data_bus_busy_n_o <= !((ph_next == `SBDP_PH_XFER) ||
                             (ph_next == `SBDP_PH_GAP));
      data_bus_busy_n_oe_o <= (ph_next != `SBDP_PH_IDLE);
      data_valid_n_oe_o <= (ph_next != `SBDP_PH_IDLE);
      data_n_oe_o <= (ph_next != `SBDP_PH_IDLE);
      group_invert_n_oe_o <= (ph_next != `SBDP_PH_IDLE);
      data_strobe_oe_o <= (ph_next != `SBDP_PH_IDLE);
      if (beat_go) begin
        // Valid low on each transfer beat [R11]
        data_valid_n_o <= 1'b0;
        // Wires active low: drive complement of coded value [R15]
        data_n_o <= ~enc_wire;
        group_invert_n_o <= ~enc_inv; // [R4] [R5]
        last_wire_reg <= enc_wire;
        beat_reg <= beat_reg + 2'h1;
        // One strobe falls per beat: pos on even, neg on odd [R14]
        // Toggling alone would give rising edges on half the beats
        data_strobe_pos_n_o <= {NG{beat_reg[0]}};
        data_strobe_neg_n_o <= {NG{~beat_reg[0]}};
      end else begin
        data_valid_n_o <= 1'b1; // [R12]
        data_strobe_pos_n_o <= {NG{1'b1}};
        data_strobe_neg_n_o <= {NG{1'b1}};
      end
      if (ph_next == `SBDP_PH_IDLE) begin
        beat_reg <= 2'h0;
        data_strobe_pos_n_o <= {NG{1'b1}};
        data_strobe_neg_n_o <= {NG{1'b1}};
      end
    end
  end

  // Receive: capture per group on strobe falling edges while valid
  reg [DW-1:0] rx_acc_reg;
  reg [NG-1:0] got_reg;
  // Own strobes echo through the syncs for a few cycles after release
  reg [2:0] own_hist_reg;
  wire [NG-1:0] grp_fall = sp_fall | sn_fall;
  wire rx_open = (ph_reg == `SBDP_PH_IDLE) && (own_hist_reg == 3'h0);
  integer i;
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_acc_reg <= {DW{1'b0}};
      got_reg <= {NG{1'b0}};
      own_hist_reg <= 3'h0;
      rx_data_o <= {DW{1'b0}};
      rx_valid_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      own_hist_reg <= {own_hist_reg[1:0], ph_reg != `SBDP_PH_IDLE};
      // Clear first so a capture in the same cycle wins
      if (&got_reg) begin
        rx_data_o <= rx_acc_reg;
        rx_valid_o <= 1'b1;
        got_reg <= {NG{1'b0}};
      end
      for (i = 0; i < NG; i = i + 1) begin
        // No capture while valid is high: idle clock [R12] [R14]
        if (grp_fall[i] && far_valid && rx_open) begin
          rx_acc_reg[i*GW +: GW] <= inv_s2_reg[i] ?
            ~din_s2_reg[i*GW +: GW] : din_s2_reg[i*GW +: GW]; // [R4]
          got_reg[i] <= 1'b1;
        end
      end
    end
  end

  // Order_n_a seen from far agent, bus free and sleep state
  reg slp_reg, slp_next;
  always @* begin
    slp_next = slp_reg;
    case (slp_reg)
      `SBDP_ST_SLEEP: if (!dslp_s_reg[1]) slp_next = `SBDP_ST_DEEP; // [R7]
      `SBDP_ST_DEEP: if (dslp_s_reg[1]) slp_next = `SBDP_ST_SLEEP; // [R8]
      default: slp_next = `SBDP_ST_SLEEP;
    endcase
  end
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slp_reg <= `SBDP_ST_SLEEP;
      deep_sleep_o <= 1'b0;
      order_n_a_seen_o <= 1'b0;
      bus_free_o <= 1'b0;
    end else begin
      slp_reg <= slp_next;
      deep_sleep_o <= (slp_next == `SBDP_ST_DEEP);
      order_n_a_seen_o <= ~order_n_a_s_reg[1]; // [R3]
      bus_free_o <= !far_busy && (ph_reg == `SBDP_PH_IDLE); // [R2]
    end
  end
  // Power control input deliberately unused [R10]
  wire unused_pwr = input_buffer_power_ctl_n_i | bclk_rise;
endmodule // sbdp_top

// ==== sbdp_defines.vh ====
// Purpose: Shared constants for the system bus data phase block
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef SBDP_DEFINES_VH
`define SBDP_DEFINES_VH
`define SBDP_DATA_W 64
`define SBDP_GRP_W 16
`define SBDP_NGRP 4
`define SBDP_BEATS 4
`define SBDP_HALF 8
`define SBDP_ST_SLEEP 1'b0
`define SBDP_ST_DEEP 1'b1
`define SBDP_PH_IDLE 2'h0
`define SBDP_PH_XFER 2'h1
`define SBDP_PH_GAP 2'h2
`define SBDP_PH_REL 2'h3
`endif

// ==== sbdp_group_inv.v ====
// Purpose: Bus-inversion coder for one data group
// Assumes: Purely combinational, called per beat
// Notes: Compares next value with the last wire level
`timescale 1ns/1ps
`include "sbdp_defines.vh"
module sbdp_group_inv #(
  parameter W = 16
) (
  input wire [W-1:0] data_i,
  input wire [W-1:0] last_wire_i,
  output reg [W-1:0] wire_o,
  output reg inv_o
);
  integer k;
  reg [5:0] cnt;
  always @* begin
    cnt = 6'h00;
    for (k = 0; k < W; k = k + 1) begin
      cnt = cnt + {5'h00, data_i[k] ^ last_wire_i[k]};
    end
    // More than half changing: invert [R5] [R15]
    inv_o = (cnt > (W / 2));
    wire_o = inv_o ? ~data_i : data_i; // [R4]
  end
endmodule // sbdp_group_inv

// ==== sbdp_top_monitor.sv ====
// Purpose: Pin-level checker for the data phase block
// Assumes: Bound into sbdp_top; one clock domain
// Notes: Watches block outputs plus tx_data_i and deep_sleep_req_n_i
`timescale 1ns/1ps
module sbdp_top_monitor (
  input wire core_clk_i,
  input wire nrst_i,
  input wire deep_sleep_req_n_i,
  input wire [63:0] tx_data_i,
  input wire tx_ready_o,
  input wire data_bus_busy_n_o,
  input wire data_bus_busy_n_oe_o,
  input wire data_valid_n_o,
  input wire [63:0] data_n_o,
  input wire [3:0] group_invert_n_o,
  input wire rx_valid_o,
  input wire deep_sleep_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  reg [63:0] last_w;
  always @(posedge core_clk_i or negedge nrst_i)
    if (!nrst_i) last_w <= 64'h0;
    else if (!data_valid_n_o) last_w <= ~data_n_o;
  function automatic bit few(input [63:0] d);
    few = 1'b1;
    for (int g = 0; g < 4; g++)
      if ($countones(d[g*16+:16]) > 8) few = 1'b0;
  endfunction
  function automatic [63:0] dec(input [63:0] w, input [3:0] i);
    for (int g = 0; g < 4; g++)
      dec[g*16+:16] = w[g*16+:16] ^ {16{~i[g]}};
  endfunction
  chk_busy_own: assert property (
    tx_ready_o |-> !data_bus_busy_n_o && data_bus_busy_n_oe_o)
    else $error("busy not low while owning");
  chk_valid_owned: assert property (
    !data_valid_n_o |-> $past(!data_bus_busy_n_o) && data_bus_busy_n_oe_o)
    else $error("valid outside ownership");
  chk_release_once: assert property (
    $rose(data_bus_busy_n_o) && data_bus_busy_n_oe_o |=> !data_bus_busy_n_oe_o)
    else $error("busy release not one cycle");
  chk_toggle_cap: assert property (
    !data_valid_n_o |-> few(~data_n_o ^ last_w))
    else $error("group toggles more than half");
  chk_inv_decode: assert property (
    !data_valid_n_o |-> dec(~data_n_o, group_invert_n_o) == $past(tx_data_i))
    else $error("wire does not decode to word");
  chk_sleep_enter: assert property (
    !deep_sleep_req_n_i [*4] |=> deep_sleep_o)
    else $error("no deep sleep entry");
  chk_sleep_leave: assert property (
    deep_sleep_req_n_i [*4] |=> !deep_sleep_o)
    else $error("no return to sleep");
  chk_rx_pulse: assert property (
    rx_valid_o |=> !rx_valid_o)
    else $error("receive pulse too long");
  cover property (!data_valid_n_o ##1 !data_valid_n_o);
  cover property (rx_valid_o);
  cover property (deep_sleep_o);
endmodule // sbdp_top_monitor
bind sbdp_top sbdp_top_monitor u_mon (.core_clk_i, .nrst_i,
  .deep_sleep_req_n_i, .tx_data_i, .tx_ready_o, .data_bus_busy_n_o,
  .data_bus_busy_n_oe_o, .data_valid_n_o, .data_n_o, .group_invert_n_o,
  .rx_valid_o, .deep_sleep_o);

// ==== sbdp_far_agent.sv ====
// Purpose: Far bus agent sending words into the block
// Assumes: Paced by the common bus clock
// Notes: Released data shows its inverse, never a stale level
`timescale 1ns/1ps
module sbdp_far_agent (
  input wire bus_clk_i,
  output reg busy_n_o = 1'b1,
  output reg valid_n_o = 1'b1,
  output reg [63:0] data_n_o = 64'h0,
  output reg [3:0] inv_n_o = 4'hf,
  output reg [3:0] pos_n_o = 4'hf,
  output reg [3:0] neg_n_o = 4'hf
);
  reg [63:0] last_w = 64'h0;
  // Changes land after the edge so the core clock never races them
  task send(input [63:0] w, input bit on_neg);
    reg [63:0] c;
    reg [3:0] inv_n;
    c = w;
    for (int g = 0; g < 4; g++) begin
      inv_n[g] = $countones(w[g*16+:16] ^ last_w[g*16+:16]) <= 8;
      if (!inv_n[g]) c[g*16+:16] = ~w[g*16+:16];
    end
    last_w = c;
    @(posedge bus_clk_i);
    busy_n_o <= 1'b0;
    inv_n_o <= inv_n;
    data_n_o <= ~c;
    valid_n_o <= 1'b0;
    @(posedge bus_clk_i);
    if (on_neg) neg_n_o <= 4'h0;
    else pos_n_o <= 4'h0;
    @(posedge bus_clk_i);
    pos_n_o <= 4'hf;
    neg_n_o <= 4'hf;
    valid_n_o <= 1'b1;
    data_n_o <= c;
    inv_n_o <= ~inv_n;
    @(posedge bus_clk_i);
    busy_n_o <= 1'b1;
  endtask
endmodule // sbdp_far_agent

// ==== sbdp_top_tb.sv ====
// Purpose: Self-checking bench for the data phase block
// Assumes: Far agent model on a free-running bus clock
// Notes: Inputs change on the falling core clock edge
`timescale 1ns/1ps
module sbdp_top_tb;
  reg core_clk_i = 1'b0;
  reg nrst_i = 1'b0;
  reg bclk = 1'b0;
  reg start = 1'b0;
  reg bv = 1'b0;
  reg last = 1'b0;
  reg dsr_n = 1'b1;
  reg pwr_n = 1'b1;
  reg ord_n = 1'b1;
  reg [63:0] txd = 64'h0;
  reg [63:0] ref_w = 64'h0;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  wire rdy, bz, bz_oe, vl, vl_oe, d_oe, i_oe, s_oe, rxv, dfr, bfree, dsl;
  wire fbz, fvl;
  wire [63:0] d_o, rxd, fd;
  wire [3:0] i_o, sp, sn, fi, fsp, fsn;
  always #5 core_clk_i = ~core_clk_i;
  always #80 bclk = ~bclk;
  sbdp_far_agent FAR (.bus_clk_i(bclk), .busy_n_o(fbz), .valid_n_o(fvl),
    .data_n_o(fd), .inv_n_o(fi), .pos_n_o(fsp), .neg_n_o(fsn));
  sbdp_top DUT (.core_clk_i, .nrst_i, .bus_clk_i(bclk), .tx_start_i(start),
    .tx_beat_valid_i(bv), .tx_data_i(txd), .tx_last_i(last),
    .tx_ready_o(rdy), .data_bus_busy_n_i(fbz & (bz | ~bz_oe)),
    .data_bus_busy_n_o(bz), .data_bus_busy_n_oe_o(bz_oe),
    .data_valid_n_i(fvl & (vl | ~vl_oe)), .data_valid_n_o(vl),
    .data_valid_n_oe_o(vl_oe), .data_n_i(d_oe ? d_o : fd), .data_n_o(d_o),
    .data_n_oe_o(d_oe), .group_invert_n_i(i_oe ? i_o : fi),
    .group_invert_n_o(i_o), .group_invert_n_oe_o(i_oe),
    .data_strobe_pos_n_i(s_oe ? sp : fsp),
    .data_strobe_neg_n_i(s_oe ? sn : fsn), .data_strobe_pos_n_o(sp),
    .data_strobe_neg_n_o(sn), .data_strobe_oe_o(s_oe), .order_n_a_i(ord_n),
    .deep_sleep_req_n_i(dsr_n), .input_buffer_power_ctl_n_i(pwr_n),
    .rx_data_o(rxd), .rx_valid_o(rxv), .order_n_a_seen_o(dfr),
    .bus_free_o(bfree), .deep_sleep_o(dsl));
  task close_out;
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string n, input [63:0] seen, input [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask
  function automatic [67:0] code(input [63:0] w, input [63:0] lw);
    code = {4'hf, w};
    for (int g = 0; g < 4; g++)
      if ($countones(w[g*16+:16] ^ lw[g*16+:16]) > 8) begin
        code[64+g] = 1'b0;
        code[g*16+:16] = ~w[g*16+:16];
      end
  endfunction
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      close_out;
    end
  end
  // Burst with a boundary of eight toggles and one idle clock
  task t_send;
    reg [63:0] ws [0:3];
    reg [67:0] e;
    int j;
    ws = '{64'hffff_ffff_ffff_ffff, 64'h00ff_01ff_ffff_0000, 64'h0,
      64'h1234_5678_9abc_def0};
    j = 0;
    @(negedge core_clk_i) start = 1'b1;
    while (!rdy) @(negedge core_clk_i);
    start = 1'b0;
    for (int i = 0; i < 5; i++) begin
      bv = (i != 2);
      txd = ws[j];
      last = (i == 4);
      @(negedge core_clk_i);
      chk("busy", bz, i == 4);
      chk("valid", vl, i == 2);
      chk("ready", rdy, i != 4);
      chk("drive oe", {s_oe, vl_oe, d_oe, i_oe}, 4'hf);
      if (i != 2) begin
        e = code(ws[j], ref_w);
        chk("wire", ~d_o, e[63:0]);
        chk("invert", i_o, e[67:64]);
        chk("strobe pos", sp, j[0] ? 4'hf : 4'h0);
        chk("strobe neg", sn, j[0] ? 4'h0 : 4'hf);
        ref_w = e[63:0];
        j++;
      end else begin
        chk("strobe gap", {sp, sn}, 8'hff);
      end
    end
    bv = 1'b0;
    last = 1'b0;
    @(negedge core_clk_i) chk("busy oe", bz_oe, 0);
    chk("drive off", {s_oe, vl_oe, d_oe, i_oe}, 4'h0);
    chk("strobe idle", {sp, sn}, 8'hff);
  endtask
  // Far agent owns the bus: refusal, order_n_a and decoding
  task t_recv;
    reg [63:0] w;
    w = 64'hf0f0_0001_ffff_8000;
    ord_n = 1'b0;
    for (int k = 0; k < 2; k++) begin
      fork FAR.send(w, k == 1); join_none
      wait (!fbz);
      // Far busy needs the synchroniser delay before it can refuse
      repeat (2) @(negedge core_clk_i);
      @(negedge core_clk_i) start = 1'b1;
      repeat (4) @(negedge core_clk_i) chk("ready", rdy, 0);
      start = 1'b0;
      chk("order_n_a", dfr, 1);
      while (!rxv) @(negedge core_clk_i);
      chk("rx", rxd, w);
      w = ~w;
      wait (fbz);
    end
    ord_n = 1'b1;
    wait (fbz);
    repeat (4) @(negedge core_clk_i);
    chk("free", bfree, 1);
    chk("order_n_a", dfr, 0);
  endtask
  // Power control toggles must not disturb the sleep states
  task t_sleep;
    @(negedge core_clk_i) dsr_n = 1'b0;
    repeat (5) @(negedge core_clk_i) pwr_n = ~pwr_n;
    chk("deep", dsl, 1);
    dsr_n = 1'b1;
    repeat (5) @(negedge core_clk_i) pwr_n = ~pwr_n;
    chk("deep", dsl, 0);
  endtask
  initial begin
    repeat (3) @(negedge core_clk_i);
    nrst_i = 1'b1;
    t_send;
    t_recv;
    t_sleep;
    close_out;
  end
endmodule // sbdp_top_tb
